// ===== rtl/hpc_pkg.sv
// constants and carrier types for the host port control and access block
package hpc_pkg;
  // =====================================================
  // register select codes
  localparam logic [1:0] SEL_CTRL     = 2'h0; // control word
  localparam logic [1:0] SEL_DATA_INC = 2'h1; // data with auto-increment
  localparam logic [1:0] SEL_ADDR     = 2'h2; // memory pointer
  localparam logic [1:0] SEL_DATA     = 2'h3; // data, pointer unchanged
  // =====================================================
  // control word bit positions, low byte and core view
  localparam int CTL_HOST_INTERRUPT_FLAG = 3; // host interrupt flag
  localparam int CTL_DINT = 2; // core interrupt request
  localparam int CTL_SHARED_MODE_BIT = 1; // shared mode bit
  localparam int CTL_BOB  = 0; // byte order bit
  // =====================================================
  // sizes, reset values and counts
  localparam int          MEM_AW      = 11;      // shared memory index
  localparam int          MEM_WORDS   = 2048;    // shared memory depth
  localparam int          XFER_CYCLES = 5;       // ready low after access
  localparam logic [2:0]  XFER_CNT    = 3'h5;    // same, at counter width
  localparam logic        RST_SHARED_MODE_BIT    = 1'b0;    // shared mode in reset
  localparam logic        RST_HOST_INTERRUPT_FLAG    = 1'b0;    // host interrupt flag
  localparam logic        RST_BOB     = 1'b0;    // byte order
  localparam logic [15:0] RST_ADDR    = 16'h0000; // memory pointer
  localparam logic [15:0] RST_LATCH   = 16'h0000; // data latches
  // =====================================================
  // carriers
  typedef struct packed {
    logic       csN;  // chip select, low active
    logic       dsAN; // data strobe a
    logic       dsBN; // data strobe b
    logic       rw;   // high reads
    logic       bil;  // second byte when high
    logic [1:0] sel;  // register select
    logic [7:0] data; // host byte bus
  } hpc_pins_t;
  typedef struct packed {
    logic [1:0] sel;
    logic       rw;
    logic       bil;
  } hpc_cyc_t;
  // host cycle states, gray along idle, transfer, busy
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_BUSY = 2'b11
  } hpc_state_t;
endpackage

// ===== rtl/hpc_host_port.sv
// byte-wide host port with control word and shared memory
`timescale 1ns/1ps
// Overview of operation
// [R1] byte order bit picks first-byte significance
// [R2] only host writes byte order; core cannot see
// [R3] shared mode zero in reset, one after
// [R4] host writing one raises core interrupt
// [R5] core sets host flag, pin goes low
// [R6] host clears flag by writing one
// [R7] host reads mirrored control halves
// [R8] host write bits taken from the second byte only
// [R9] core read shows flag and shared mode
// [R10] core write updates flag and shared mode
// [R11] host two bytes, core one word
// [R12] each host control byte samples live bits
// [R13] host sets control, pointer, then data
// [R14] pointer or data write starts internal transfer
// [R15] read after write returns written data
// [R16] host rereads to avoid stale prefetch
// [R17] ready low during internal transfer
// [R18] ready low five cycles after waited access
// [R19] ready high while chip select high
// [R20] no wait for control and pointer reads
// [R21] host sets selects before data strobe
// [R22] register select chooses access target
// [R23] auto-increment after read, before write
// [R24] low eleven pointer bits index memory
// [R25] host pairs low then high byte
// [R26] core interrupt is one-clock pulse
module hpc_host_port (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        portChipSelect_n,
  input  wire logic        dataStrobeA_n,
  input  wire logic        dataStrobeB_n,
  input  wire logic        readWriteSelect,
  input  wire logic        byteIdentifier,
  input  wire logic [1:0]  registerSelect,
  input  wire logic [7:0]  hostByteBusIn,
  output logic      [7:0]  hostByteBusOut,
  output logic             hostByteBusOe_n,
  output logic             portReadyOut,
  output logic             hostInterrupt_n,
  output logic             coreInterruptRequest,
  input  wire logic        coreCtrlWrite,
  input  wire logic [15:0] coreCtrlWdata,
  output logic      [15:0] coreCtrlRdata,
  output logic             sharedModeBit,
  input  wire logic        coreMemEn,
  input  wire logic        coreMemWe,
  input  wire logic [10:0] coreMemAddr,
  input  wire logic [15:0] coreMemWdata,
  output logic      [15:0] coreMemRdata
);
  // =====================================================
  // pin synchronisers
  hpc_pkg::hpc_pins_t pinMeta_r; // first stage, read only by second
  hpc_pkg::hpc_pins_t pin_r;     // second stage, safe to use
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta_r <= '1;
      pin_r     <= '1;
    end else begin
      pinMeta_r <= {portChipSelect_n, dataStrobeA_n, dataStrobeB_n,
                    readWriteSelect, byteIdentifier, registerSelect,
                    hostByteBusIn};
      pin_r     <= pinMeta_r;
    end
  end
  // =====================================================
  // strobe decode and state
  logic                  strobe;   // chip select with one data strobe
  hpc_pkg::hpc_state_t   state_r;  // host cycle state
  hpc_pkg::hpc_state_t   state_nxt;
  hpc_pkg::hpc_cyc_t     cyc_r;    // controls caught at strobe start
  logic [2:0]            busyCnt_r; // internal transfer countdown
  logic                  strbStart; // strobe opens
  logic                  strbStop;  // strobe closes
  logic                  waited;    // closing access uses ready
  logic                  lastByte;  // closing byte is second of pair
  logic                  shared_mode_bit_r;
  logic                  smodDone_r; // reset release seen
  logic                  host_interrupt_flag_r;
  logic                  bob_r;
  logic [15:0]           addr_r;    // shared memory pointer
  logic [15:0]           addrNxt;
  logic [15:0]           latch_r;   // shared data latches
  logic [15:0]           latchNxt;
  logic [15:0]           mem [hpc_pkg::MEM_WORDS]; // shared memory
  // both strobes low is not a valid strobe
  assign strobe    = !pin_r.csN && (pin_r.dsAN ^ pin_r.dsBN);
  assign strbStart = strobe && (state_r != hpc_pkg::ST_XFER);
  assign strbStop  = !strobe && (state_r == hpc_pkg::ST_XFER);
  assign lastByte  = strbStop && cyc_r.bil;
  // waits for data, pointer writes, control writes with flag or request bit set
  always_comb begin
    case (cyc_r.sel)
      hpc_pkg::SEL_CTRL: waited = !cyc_r.rw &&                  // R20
        (pin_r.data[hpc_pkg::CTL_HOST_INTERRUPT_FLAG] || pin_r.data[hpc_pkg::CTL_DINT]);
      hpc_pkg::SEL_ADDR: waited = !cyc_r.rw;                    // R20
      default:           waited = 1'b1;
    endcase
  end
  // high lane when first byte under bob 0 or second under bob 1
  function automatic logic hiLane(input logic bil, input logic byte_order_bit);
    hiLane = !(bil ^ byte_order_bit); // R1
  endfunction
  function automatic logic [15:0] putByte(input logic [15:0] w,
      input logic hi, input logic [7:0] b);
    putByte = hi ? {b, w[7:0]} : {w[15:8], b};
  endfunction
  // -----------------------------------------------------
  // next state
  always_comb begin
    case (state_r)
      hpc_pkg::ST_IDLE: state_nxt = strobe ? hpc_pkg::ST_XFER
                                           : hpc_pkg::ST_IDLE;
      hpc_pkg::ST_XFER: begin
        if (strobe) begin
          state_nxt = hpc_pkg::ST_XFER;
        end else if (waited) begin
          state_nxt = hpc_pkg::ST_BUSY;
        end else begin
          state_nxt = hpc_pkg::ST_IDLE;
        end
      end
      hpc_pkg::ST_BUSY: begin
        if (strobe) begin
          state_nxt = hpc_pkg::ST_XFER;
        end else if (busyCnt_r == 3'h1) begin
          state_nxt = hpc_pkg::ST_IDLE;
        end else begin
          state_nxt = hpc_pkg::ST_BUSY;
        end
      end
      default: state_nxt = hpc_pkg::ST_IDLE;
    endcase
  end
  // state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= hpc_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end
  // busy countdown loaded as each waited byte closes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busyCnt_r <= 3'h0;
    end else if (strbStop && waited) begin
      busyCnt_r <= hpc_pkg::XFER_CNT; // R18
    end else if (state_r == hpc_pkg::ST_BUSY) begin
      busyCnt_r <= busyCnt_r - 3'h1;
    end
  end
  // controls caught as strobe opens
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_r <= '0;
    end else if (strbStart) begin
      cyc_r <= {pin_r.sel, pin_r.rw, pin_r.bil};
    end
  end
  // ready: high without chip select, low while busy
  assign portReadyOut = pin_r.csN ||                       // R19
                        (state_r != hpc_pkg::ST_BUSY);     // R17
  // =====================================================
  // control word
  // shared mode: zero in reset, one after, then core-owned
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shared_mode_bit_r     <= hpc_pkg::RST_SHARED_MODE_BIT; // R3
      smodDone_r <= 1'b0;
    end else begin
      smodDone_r <= 1'b1;
      if (!smodDone_r) begin
        shared_mode_bit_r <= 1'b1; // R3
      end else if (coreCtrlWrite) begin
        shared_mode_bit_r <= coreCtrlWdata[hpc_pkg::CTL_SHARED_MODE_BIT]; // R10
      end
    end
  end
  // host flag: core sets, host clears, set wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      host_interrupt_flag_r <= hpc_pkg::RST_HOST_INTERRUPT_FLAG; // R5
    end else if (coreCtrlWrite && coreCtrlWdata[hpc_pkg::CTL_HOST_INTERRUPT_FLAG]) begin
      host_interrupt_flag_r <= 1'b1; // R5
    end else if (lastByte && !cyc_r.rw && cyc_r.sel == hpc_pkg::SEL_CTRL
                 && pin_r.data[hpc_pkg::CTL_HOST_INTERRUPT_FLAG]) begin
      host_interrupt_flag_r <= 1'b0; // R6
    end
  end
  assign hostInterrupt_n = !host_interrupt_flag_r; // R5
  // byte order: host only, from the second byte
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bob_r <= hpc_pkg::RST_BOB;
    end else if (lastByte && !cyc_r.rw &&
                 cyc_r.sel == hpc_pkg::SEL_CTRL) begin
      bob_r <= pin_r.data[hpc_pkg::CTL_BOB]; // R2 R8
    end
  end
  // core interrupt pulse, once per control word write with request bit set
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      coreInterruptRequest <= 1'b0;
    end else begin
      coreInterruptRequest <= lastByte && !cyc_r.rw &&        // R26
        cyc_r.sel == hpc_pkg::SEL_CTRL && pin_r.data[hpc_pkg::CTL_DINT]; // R4
    end
  end
  // core view: bob and interrupt request read as zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      coreCtrlRdata <= 16'h0000;
    end else begin
      coreCtrlRdata <= {12'h000, host_interrupt_flag_r, 1'b0, shared_mode_bit_r, 1'b0}; // R9 R11
    end
  end
  assign sharedModeBit = shared_mode_bit_r;
  // =====================================================
  // pointer, latches and shared memory
  // pointer bytes, pre-increment on auto-increment write
  always_comb begin
    addrNxt = addr_r;
    if (strbStop && !cyc_r.rw && cyc_r.sel == hpc_pkg::SEL_ADDR) begin
      addrNxt = putByte(addr_r, hiLane(cyc_r.bil, bob_r), pin_r.data);
    end else if (lastByte && cyc_r.sel == hpc_pkg::SEL_DATA_INC
                 && !cyc_r.rw) begin
      addrNxt = addr_r + 16'h0001; // R23
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= hpc_pkg::RST_ADDR;
    end else if (lastByte && cyc_r.rw &&
                 cyc_r.sel == hpc_pkg::SEL_DATA_INC) begin
      addr_r <= addr_r + 16'h0001; // R23
    end else begin
      addr_r <= addrNxt;
    end
  end
  // host byte written into its latch lane
  assign latchNxt = putByte(latch_r, hiLane(cyc_r.bil, bob_r),
                            pin_r.data);
  // latches: filled by host writes or by prefetch reads
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= hpc_pkg::RST_LATCH;
    end else if (strbStop && !cyc_r.rw && cyc_r.sel[0]) begin
      latch_r <= latchNxt; // R15
    end else if (lastByte && cyc_r.sel == hpc_pkg::SEL_ADDR
                 && !cyc_r.rw) begin
      latch_r <= mem[addrNxt[hpc_pkg::MEM_AW-1:0]]; // R14 R24
    end else if (lastByte && cyc_r.rw && cyc_r.sel[0]) begin
      latch_r <= mem[(cyc_r.sel == hpc_pkg::SEL_DATA_INC) // R23
        ? addr_r[hpc_pkg::MEM_AW-1:0] + 11'h001
        : addr_r[hpc_pkg::MEM_AW-1:0]];                   // R14
    end
  end
  // memory writes: host deferred word, core only in shared mode
  always_ff @(posedge mclk) begin
    if (lastByte && !cyc_r.rw && cyc_r.sel[0]) begin
      mem[addrNxt[hpc_pkg::MEM_AW-1:0]] <= latchNxt; // R14 R24
    end else if (coreMemEn && coreMemWe && shared_mode_bit_r) begin
      mem[coreMemAddr] <= coreMemWdata; // R3
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      coreMemRdata <= 16'h0000;
    end else if (coreMemEn && !coreMemWe && shared_mode_bit_r) begin
      coreMemRdata <= mem[coreMemAddr];
    end
  end
  // =====================================================
  // host read data, sampled live as each strobe opens
  logic [15:0] rdWord; // word of the selected register
  always_comb begin
    case (pin_r.sel) // R22
      hpc_pkg::SEL_CTRL: rdWord = {4'h0, host_interrupt_flag_r, 1'b0, shared_mode_bit_r, bob_r,
                                   4'h0, host_interrupt_flag_r, 1'b0, shared_mode_bit_r, bob_r}; // R7
      hpc_pkg::SEL_ADDR: rdWord = addr_r;
      default:           rdWord = latch_r; // R14
    endcase
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hostByteBusOut <= 8'h00;
    end else if (strbStart) begin
      hostByteBusOut <= hiLane(pin_r.bil, bob_r) ? rdWord[15:8] // R12
                                                  : rdWord[7:0];
    end
  end
  // drive while a read strobe stands
  assign hostByteBusOe_n = !(state_r == hpc_pkg::ST_XFER && cyc_r.rw);
  // =====================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ready_cs_a: assert property (pin_r.csN |-> portReadyOut) // R19
    else $error("ready low without chip select");
  ready_wait_a: assert property (strbStop && waited && !pin_r.csN
    |=> !portReadyOut [*4]) // R18
    else $error("ready released early");
  ready_end_a: assert property (strbStop && waited |->
    ##[1:7] (portReadyOut || strobe)) // R17
    else $error("ready stuck low");
  no_wait_a: assert property (strbStop && cyc_r.rw &&       // R20
    cyc_r.sel == hpc_pkg::SEL_ADDR |=> portReadyOut)
    else $error("pointer read waited");
  shared_mode_bit_up_a: assert property ($rose(smodDone_r) |-> shared_mode_bit_r) // R3
    else $error("shared mode not set after reset");
  host_interrupt_flag_pin_a: assert property (hostInterrupt_n == !host_interrupt_flag_r) // R5
    else $error("flag and pin differ");
  host_interrupt_flag_set_a: assert property (coreCtrlWrite &&           // R5
    coreCtrlWdata[hpc_pkg::CTL_HOST_INTERRUPT_FLAG] |=> host_interrupt_flag_r)
    else $error("core set lost");
  core_rd_a: assert property (##1 coreCtrlRdata[hpc_pkg::CTL_BOB] == 1'b0
    && coreCtrlRdata[hpc_pkg::CTL_DINT] == 1'b0) // R9
    else $error("hidden bits visible");
  dint_pulse_a: assert property (coreInterruptRequest
    |=> !coreInterruptRequest) // R26
    else $error("core interrupt longer than one clock");
  inc_read_a: assert property (lastByte && cyc_r.rw &&      // R23
    cyc_r.sel == hpc_pkg::SEL_DATA_INC |=> addr_r == $past(addr_r) + 16'h1)
    else $error("pointer not incremented");
  host_interrupt_flag_clr_a: assert property (lastByte && !cyc_r.rw &&      // R6
    cyc_r.sel == hpc_pkg::SEL_CTRL && pin_r.data[hpc_pkg::CTL_HOST_INTERRUPT_FLAG]
    && !coreCtrlWrite |=> !host_interrupt_flag_r)
    else $error("host clear lost");
  data_wr_c: cover property (lastByte && !cyc_r.rw && cyc_r.sel[0]);
  data_rd_c: cover property (lastByte && cyc_r.rw && cyc_r.sel[0]);
  dint_c: cover property (coreInterruptRequest);
  host_interrupt_flag_clr_c: cover property ($fell(host_interrupt_flag_r));
endmodule

// ===== testbench/hpc_host_model.sv
// host processor model that drives the byte-wide port pins
`timescale 1ns/1ps
module hpc_host_model (
  input  wire logic        mclk,
  input  wire logic [7:0]  rdByte,
  input  wire logic        ready,
  output hpc_pkg::hpc_pins_t pins,
  output logic             hung
);
  // ==========
  // idle pins: deselected, strobes high, bus at zero
  initial begin
    pins = {1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2'h0, 8'h00};
    hung = 1'b0;
  end
  // ==========
  // one byte cycle; counts ready-low clocks after the strobe ends
  task automatic byte_cyc(input logic [1:0] sel, input logic rw,
      input logic bil, input logic [7:0] wb, output logic [7:0] rb,
      output int lowCnt);
    int n;
    n = 0;
    lowCnt = 0;
    // honour ready before a new strobe, under a bound
    while (ready !== 1'b1 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 40) begin
      hung <= 1'b1;
    end
    @(posedge mclk);
    // selects and chip select settle before the strobe
    pins.csN <= 1'b0;
    pins.sel <= sel;
    pins.rw  <= rw;
    pins.bil <= bil;
    // a released bus shows the inverse of its last value
    pins.data <= rw ? ~pins.data : wb;
    repeat (3) @(posedge mclk);
    // second byte uses the other strobe so both inputs are exercised
    if (bil) begin
      pins.dsBN <= 1'b0;
    end else begin
      pins.dsAN <= 1'b0;
    end
    repeat (6) @(posedge mclk);
    rb = rdByte;
    pins.dsAN <= 1'b1;
    pins.dsBN <= 1'b1;
    repeat (12) begin
      @(posedge mclk);
      if (ready === 1'b0) begin
        lowCnt++;
      end
    end
    pins.csN <= 1'b1;
    @(posedge mclk);
  endtask
  // ==========
  // whole access: first byte low identifier, then high
  task automatic word(input logic [1:0] sel, input logic rw,
      input logic [15:0] wr, output logic [15:0] rd, output int lowCnt);
    byte_cyc(sel, rw, 1'b0, wr[15:8], rd[15:8], lowCnt);
    byte_cyc(sel, rw, 1'b1, wr[7:0], rd[7:0], lowCnt);
  endtask
endmodule

// ===== testbench/tb.sv
// self-checking bench for the host port control and access block
`timescale 1ns/1ps
module tb;
  logic               mclk, rst_n, coreCtrlWrite, coreMemEn, coreMemWe;
  logic        [15:0] coreCtrlWdata, coreMemWdata, coreCtrlRdata;
  logic        [15:0] coreMemRdata, rd;
  logic        [10:0] coreMemAddr;
  logic         [7:0] hostByteBusOut, b0, b1;
  logic               hostByteBusOe_n, portReadyOut, hostInterrupt_n;
  logic               coreInterruptRequest, sharedModeBit, hung;
  hpc_pkg::hpc_pins_t pins;
  int                 nErrors, nTests, nIrq, nOe, lc;
  // ==========
  // device and host model
  hpc_host_port hpc_host_port_i (.mclk, .rst_n,
    .portChipSelect_n(pins.csN), .dataStrobeA_n(pins.dsAN),
    .dataStrobeB_n(pins.dsBN), .readWriteSelect(pins.rw),
    .byteIdentifier(pins.bil), .registerSelect(pins.sel),
    .hostByteBusIn(pins.data), .hostByteBusOut, .hostByteBusOe_n,
    .portReadyOut, .hostInterrupt_n, .coreInterruptRequest,
    .coreCtrlWrite, .coreCtrlWdata, .coreCtrlRdata, .sharedModeBit,
    .coreMemEn, .coreMemWe, .coreMemAddr, .coreMemWdata, .coreMemRdata);
  hpc_host_model host (.mclk, .rdByte(hostByteBusOut),
    .ready(portReadyOut), .pins, .hung);
  // ==========
  // clock and watchers
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) if (coreInterruptRequest === 1'b1) nIrq++;
  // clocks in which the device drives the host byte bus
  always @(posedge mclk) if (hostByteBusOe_n === 1'b0) nOe++;
  always @(posedge hung) begin
    nErrors++;
    summarize();
  end
  // ==========
  // shared helpers
  task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    nTests++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      nErrors++;
    end
  endtask
  task automatic core_wr(input logic [15:0] d);
    @(posedge mclk);
    coreCtrlWrite <= 1'b1;
    coreCtrlWdata <= d;
    @(posedge mclk);
    coreCtrlWrite <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic mem_acc(input logic we, input logic [10:0] a,
      input logic [15:0] d);
    @(posedge mclk);
    coreMemEn <= 1'b1;
    coreMemWe <= we;
    coreMemAddr <= a;
    coreMemWdata <= d;
    @(posedge mclk);
    coreMemEn <= 1'b0;
    @(posedge mclk);
    if (!we) chk("core mem", d, coreMemRdata);
  endtask
  task automatic summarize();
    $display("errors %0d comparisons %0d", nErrors, nTests);
    if (nErrors == 0 && nTests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_reset();
    chk("shared_mode_bit in reset", 16'h0, {15'h0, sharedModeBit});
    @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("shared_mode_bit after", 16'h1, {15'h0, sharedModeBit});
    chk("core view", 16'h0002, coreCtrlRdata);
    chk("host_interrupt_flag pin", 16'h1, {15'h0, hostInterrupt_n});
  endtask
  task automatic t_ctrl();
    host.word(hpc_pkg::SEL_CTRL, 1'b0, 16'h0101, rd, lc);
    chk("plain wr wait", 16'h0, 16'(lc));
    chk("no drive on write", 16'h0, 16'(nOe));
    host.word(hpc_pkg::SEL_CTRL, 1'b1, 16'h0, rd, lc);
    chk("ctrl read", 16'h0303, rd);
    chk("drive on read", 16'h000C, 16'(nOe));
    chk("ctrl rd wait", 16'h0, 16'(lc));
    chk("bob hidden", 16'h0002, coreCtrlRdata);
    core_wr(16'hFFF5);
    chk("core ignores", 16'h0000, coreCtrlRdata);
    core_wr(16'h000A);
    chk("core sets", 16'h000A, coreCtrlRdata);
    chk("pin low", 16'h0, {15'h0, hostInterrupt_n});
    host.word(hpc_pkg::SEL_CTRL, 1'b1, 16'h0, rd, lc);
    chk("ctrl flag", 16'h0B0B, rd);
    host.word(hpc_pkg::SEL_CTRL, 1'b0, 16'h0101, rd, lc);
    chk("zero kept", 16'h0, {15'h0, hostInterrupt_n});
    host.word(hpc_pkg::SEL_CTRL, 1'b0, 16'h0909, rd, lc);
    chk("clear wait", 16'h5, 16'(lc));
    chk("pin released", 16'h1, {15'h0, hostInterrupt_n});
    nIrq = 0;
    host.word(hpc_pkg::SEL_CTRL, 1'b0, 16'h0505, rd, lc);
    chk("irq pulses", 16'h1, 16'(nIrq));
    chk("irq wait", 16'h5, 16'(lc));
    host.word(hpc_pkg::SEL_CTRL, 1'b1, 16'h0, rd, lc);
    chk("irq reads 0", 16'h0303, rd);
    chk("core irq 0", 16'h0002, coreCtrlRdata);
  endtask
  task automatic t_mem();
    mem_acc(1'b1, 11'h005, 16'hA55A);
    mem_acc(1'b1, 11'h006, 16'h1234);
    host.word(hpc_pkg::SEL_ADDR, 1'b0, 16'h0508, rd, lc);
    chk("ptr wr wait", 16'h5, 16'(lc));
    host.word(hpc_pkg::SEL_DATA_INC, 1'b1, 16'h0, rd, lc);
    chk("prefetch", 16'h5AA5, rd);
    chk("data wait", 16'h5, 16'(lc));
    host.word(hpc_pkg::SEL_DATA, 1'b1, 16'h0, rd, lc);
    chk("post inc", 16'h3412, rd);
    host.word(hpc_pkg::SEL_DATA, 1'b0, 16'hEFBE, rd, lc);
    host.word(hpc_pkg::SEL_DATA, 1'b1, 16'h0, rd, lc);
    chk("read back", 16'hEFBE, rd);
    mem_acc(1'b0, 11'h006, 16'hBEEF);
    host.word(hpc_pkg::SEL_DATA_INC, 1'b0, 16'h7777, rd, lc);
    mem_acc(1'b0, 11'h007, 16'h7777);
    host.word(hpc_pkg::SEL_ADDR, 1'b1, 16'h0, rd, lc);
    chk("ptr read", 16'h0708, rd);
    chk("ptr rd wait", 16'h0, 16'(lc));
  endtask
  task automatic t_order();
    host.word(hpc_pkg::SEL_CTRL, 1'b0, 16'h0000, rd, lc);
    chk("shared_mode_bit kept", 16'h1, {15'h0, sharedModeBit});
    host.word(hpc_pkg::SEL_ADDR, 1'b0, 16'hF805, rd, lc);
    host.word(hpc_pkg::SEL_DATA, 1'b1, 16'h0, rd, lc);
    chk("msb first", 16'hA55A, rd);
    host.byte_cyc(hpc_pkg::SEL_CTRL, 1'b1, 1'b0, 8'h0, b0, lc);
    core_wr(16'h000A);
    host.byte_cyc(hpc_pkg::SEL_CTRL, 1'b1, 1'b1, 8'h0, b1, lc);
    chk("live bytes", 16'h020A, {b0, b1});
  endtask
  // ==========
  // main sequence
  initial begin
    rst_n = 1'b0;
    coreCtrlWrite = 1'b0;
    coreCtrlWdata = 16'h0000;
    coreMemEn = 1'b0;
    coreMemWe = 1'b0;
    coreMemAddr = 11'h000;
    coreMemWdata = 16'h0000;
    nErrors = 0;
    nTests = 0;
    nIrq = 0;
    nOe = 0;
    repeat (5) @(posedge mclk);
    t_reset();
    t_ctrl();
    t_mem();
    t_order();
    summarize();
  end
endmodule
